// ===== stop_ctl_defs.vh
// Constants for the stop-mode standby controller.
// Assumes a 100 MHz core clock; included by every design file.
`ifndef STOP_CTL_DEFS_VH
`define STOP_CTL_DEFS_VH

// Register indices on the plain register port
`define ADDR_CTRL 4'h0
`define ADDR_STAT 4'h1
`define ADDR_OSC_STAB_TIME_SELECT 4'h2
`define ADDR_CAUSE 4'h3

// Control register fields
`define CTRL_RL_SOFT_STOP 0
`define CTRL_RL_OSC_OFF 1
`define CTRL_EXT_HS_CLK 2
`define CTRL_UART_TIMER_COUNTER_OUTPUT_CLOCK 3
`define CTRL_TIMER_COUNTER_OUTPUT_CLOCK_RUN 4
`define CTRL_CSI_EXT 5
`define CTRL_IIC_EXT 6
`define CTRL_RESET 8'h00

// Stabilisation select reset value and width
`define OSC_STAB_TIME_SELECT_RESET 3'h5
`define OSC_STAB_TIME_SELECT_W 3

// Release waits in clocks
`define WAIT_VECTOR 5'h11
`define WAIT_SEQ 5'h0B

// Main states
`define ST_RUN 2'h0
`define ST_STOP 2'h1
`define ST_STAB 2'h2
`define ST_WAKE 2'h3

`endif

// ===== stab_counter.v
// Oscillation stabilisation counter.
// Assumes start is a one-cycle pulse; length picked by select.
`timescale 1ns/1ps
`include "stop_ctl_defs.vh"

module stab_counter (
	// Clock and reset
	input wire clk_i,
	input wire rstn_i,
	// Control
	input wire start_i,
	input wire [`OSC_STAB_TIME_SELECT_W-1:0] sel_i,
	// Status
	output reg busy_o,
	output reg done_o
);

reg [15:0] cnt_q;

// Power-of-two lengths from 2^9 up to 2^16; the top one wraps to all ones
function [15:0] stab_len;
	input [`OSC_STAB_TIME_SELECT_W-1:0] s;
	begin
		stab_len = (16'h0200 << s) - 16'h0001;
	end
endfunction

always @(posedge clk_i or negedge rstn_i) begin
	if (!rstn_i) begin
		cnt_q <= 16'h0000;
		busy_o <= 1'b0;
		done_o <= 1'b0;
	end else begin
		done_o <= 1'b0;
		if (start_i) begin
			cnt_q <= stab_len(sel_i);
			busy_o <= 1'b1;
		end else if (busy_o) begin
			if (cnt_q == 16'h0000) begin
				busy_o <= 1'b0;
				done_o <= 1'b1;
			end else begin
				cnt_q <= cnt_q - 16'h0001;
			end
		end
	end
end

endmodule

// ===== wake_decode.v
// Release decision for one maskable request.
// Assumes the flag inputs are steady while the request is raised.
`timescale 1ns/1ps
`include "stop_ctl_defs.vh"

module wake_decode (
	// Request and flags
	input wire req_i,
	input wire mask_i,
	input wire prio_i,
	input wire ie_i,
	input wire isp_i,
	// Decision
	output wire wake_o,
	output wire vector_o
);

// Masked requests never wake; low priority vectors only if in-service allows
assign wake_o = req_i & ~mask_i;
assign vector_o = wake_o & ie_i & (~prio_i | isp_i);

endmodule

// ===== stop_ctl.v
// Stop-mode standby controller: entry, peripheral gating, release.
// Assumes the CPU pulses the stop request for one cycle; reset input
// is the chip reset, which also serves as the reset release path.
//
// Summary of operation
// - Watchdog runs in stop unless low-speed oscillator soft-stop option chosen.
// - Async serial channels run in stop only on running timer 50 output.
// - Clocked serial channel runs in stop only with external serial clock.
// - Two-wire serial runs in stop only on its external clock pin.
// - Stop entry leaves the low-speed oscillator state unchanged.
// - Unmasked request wakes, waits stabilisation, then vectors or continues.
// - Wake wait is 17 clocks when vectoring, 11 clocks otherwise.
// - Reset ends stop and restarts from the reset vector.
// - External high-speed clock input skips the stabilisation wait.
// - Mask 1 holds stop; else vector when enabled and priority permits.
// - Stop accepted only when CPU runs on the main system clock.
// - Pending unmasked request at stop drops to halt, resumes after wait.
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "stop_ctl_defs.vh"

module stop_ctl (
	// Clock and reset
	input wire CLK_I,
	input wire RSTN_I,
	// Register port
	input wire [3:0] ADDR_I,
	input wire [7:0] WDATA_I,
	input wire WR_I,
	input wire RD_I,
	output reg [7:0] RDATA_O,
	// CPU core
	input wire STOP_REQ_I,
	input wire CPU_ON_MAIN_I,
	output reg CPU_CLK_EN_O,
	output reg RESUME_O,
	output reg VECTOR_O,
	output reg HALT_O,
	output reg STOP_O,
	// Interrupt flag logic
	input wire INT_REQ_I,
	input wire INT_MASK_I,
	input wire INT_PRIO_I,
	input wire INT_IE_I,
	input wire INT_ISP_I,
	// Clock generator and peripheral enables
	output reg MAIN_OSC_EN_O,
	output reg RL_OSC_EN_O,
	output reg WDT_CLK_EN_O,
	output reg UART_A_EN_O,
	output reg UART_B_EN_O,
	output reg CSI_EN_O,
	output reg IIC_EN_O,
	output reg TIMER_EN_O
);

// ----------------------------------------
// Registers
// ----------------------------------------
reg [7:0] ctrl_q;
reg [`OSC_STAB_TIME_SELECT_W-1:0] osc_stab_time_select_q;
reg [1:0] state_q;
reg [1:0] state_d;
reg [4:0] wait_q;
reg vec_q;
reg from_halt_q;
reg [1:0] cause_q;
wire wake;
wire vector;
wire stab_busy;
wire stab_done;
reg stab_start;

// Low-speed oscillator runs unless software stopped it under the option
function rl_running;
	input [7:0] ctrl;
	begin
		rl_running = ~(ctrl[`CTRL_RL_SOFT_STOP] & ctrl[`CTRL_RL_OSC_OFF]);
	end
endfunction

// Async channels survive stop only on a running timer 50 output
function uart_in_stop;
	input [7:0] ctrl;
	begin
		uart_in_stop = ctrl[`CTRL_UART_TIMER_COUNTER_OUTPUT_CLOCK] & ctrl[`CTRL_TIMER_COUNTER_OUTPUT_CLOCK_RUN];
	end
endfunction

wake_decode u_dec (
	.req_i(INT_REQ_I),
	.mask_i(INT_MASK_I),
	.prio_i(INT_PRIO_I),
	.ie_i(INT_IE_I),
	.isp_i(INT_ISP_I),
	.wake_o(wake),
	.vector_o(vector)
);

stab_counter u_stab (
	.clk_i(CLK_I),
	.rstn_i(RSTN_I),
	.start_i(stab_start),
	.sel_i(osc_stab_time_select_q),
	.busy_o(stab_busy),
	.done_o(stab_done)
);

// ----------------------------------------
// Register port
// ----------------------------------------
// Software-chosen oscillator state survives stop untouched
always @(posedge CLK_I or negedge RSTN_I) begin
	if (!RSTN_I) begin
		ctrl_q <= `CTRL_RESET;
		osc_stab_time_select_q <= `OSC_STAB_TIME_SELECT_RESET;
	end else if (WR_I) begin
		case (ADDR_I)
			`ADDR_CTRL: begin
				ctrl_q <= WDATA_I;
			end
			`ADDR_OSC_STAB_TIME_SELECT: begin
				osc_stab_time_select_q <= WDATA_I[`OSC_STAB_TIME_SELECT_W-1:0];
			end
			default: begin
			end
		endcase
	end
end

always @(posedge CLK_I or negedge RSTN_I) begin
	if (!RSTN_I) begin
		RDATA_O <= 8'h00;
	end else if (RD_I) begin
		case (ADDR_I)
			`ADDR_CTRL: RDATA_O <= ctrl_q;
			`ADDR_STAT: RDATA_O <= {4'h0, stab_busy, from_halt_q, state_q};
			`ADDR_OSC_STAB_TIME_SELECT: RDATA_O <= {5'h00, osc_stab_time_select_q};
			`ADDR_CAUSE: RDATA_O <= {6'h00, cause_q};
			default: RDATA_O <= 8'h00;
		endcase
	end else begin
		RDATA_O <= 8'h00;
	end
end

// ----------------------------------------
// Sequencer
// ----------------------------------------
always @* begin
	state_d = state_q;
	stab_start = 1'b0;
	case (state_q)
		`ST_RUN: begin
			if (STOP_REQ_I && CPU_ON_MAIN_I) begin
				if (wake) begin
					// Pending request: halt then wait as after stop
					state_d = `ST_STAB;
					stab_start = ~ctrl_q[`CTRL_EXT_HS_CLK];
				end else begin
					state_d = `ST_STOP;
				end
			end
		end
		`ST_STOP: begin
			if (wake) begin
				state_d = `ST_STAB;
				stab_start = ~ctrl_q[`CTRL_EXT_HS_CLK];
			end
		end
		`ST_STAB: begin
			if (ctrl_q[`CTRL_EXT_HS_CLK] || stab_done) begin
				state_d = `ST_WAKE;
			end
		end
		`ST_WAKE: begin
			if (wait_q == 5'h01) begin
				state_d = `ST_RUN;
			end
		end
		default: begin
			state_d = `ST_RUN;
		end
	endcase
end

// Reset releases stop through the asynchronous clear
always @(posedge CLK_I or negedge RSTN_I) begin
	if (!RSTN_I) begin
		state_q <= `ST_RUN;
		wait_q <= 5'h00;
		vec_q <= 1'b0;
		from_halt_q <= 1'b0;
		cause_q <= 2'h0;
	end else begin
		state_q <= state_d;
		if (state_q == `ST_RUN && state_d == `ST_STAB) begin
			from_halt_q <= 1'b1;
		end else if (state_q == `ST_RUN && state_d == `ST_STOP) begin
			from_halt_q <= 1'b0;
		end
		if (state_q != `ST_STAB && state_d == `ST_STAB) begin
			vec_q <= vector;
		end
		if (state_q == `ST_STAB && state_d == `ST_WAKE) begin
			// Wake wait covers the fixed CPU restart latency
			wait_q <= vec_q ? `WAIT_VECTOR : `WAIT_SEQ;
		end else if (wait_q != 5'h00) begin
			wait_q <= wait_q - 5'h01;
		end
		if (state_q == `ST_WAKE && state_d == `ST_RUN) begin
			cause_q <= {1'b1, vec_q};
		end
	end
end

// ----------------------------------------
// Outputs
// ----------------------------------------
always @(posedge CLK_I or negedge RSTN_I) begin
	if (!RSTN_I) begin
		CPU_CLK_EN_O <= 1'b1;
		RESUME_O <= 1'b0;
		VECTOR_O <= 1'b0;
		HALT_O <= 1'b0;
		STOP_O <= 1'b0;
		MAIN_OSC_EN_O <= 1'b1;
		RL_OSC_EN_O <= 1'b1;
		WDT_CLK_EN_O <= 1'b1;
		UART_A_EN_O <= 1'b1;
		UART_B_EN_O <= 1'b1;
		CSI_EN_O <= 1'b1;
		IIC_EN_O <= 1'b1;
		TIMER_EN_O <= 1'b1;
	end else begin
		CPU_CLK_EN_O <= (state_d == `ST_RUN);
		RESUME_O <= (state_q == `ST_WAKE && state_d == `ST_RUN);
		VECTOR_O <= (state_q == `ST_WAKE && state_d == `ST_RUN) && vec_q;
		HALT_O <= (state_d == `ST_STAB || state_d == `ST_WAKE) && (from_halt_q || state_q == `ST_RUN);
		STOP_O <= (state_d == `ST_STOP);
		// Main oscillator held off until the wake request
		MAIN_OSC_EN_O <= (state_d != `ST_STOP);
		// Low-speed oscillator follows software only, never the stop state
		RL_OSC_EN_O <= rl_running(ctrl_q);
		if (state_d == `ST_STOP) begin
			WDT_CLK_EN_O <= ~ctrl_q[`CTRL_RL_SOFT_STOP];
			UART_A_EN_O <= uart_in_stop(ctrl_q);
			UART_B_EN_O <= uart_in_stop(ctrl_q);
			CSI_EN_O <= ctrl_q[`CTRL_CSI_EXT];
			IIC_EN_O <= ctrl_q[`CTRL_IIC_EXT];
			TIMER_EN_O <= 1'b0;
		end else begin
			WDT_CLK_EN_O <= rl_running(ctrl_q);
			UART_A_EN_O <= 1'b1;
			UART_B_EN_O <= 1'b1;
			CSI_EN_O <= 1'b1;
			IIC_EN_O <= 1'b1;
			TIMER_EN_O <= 1'b1;
		end
	end
end

endmodule

// ===== stop_ctl_assertions.sv
// Port checker for the stop controller.
// Assumes a bind onto stop_ctl; sees its ports only.
`timescale 1ns/1ps
module stop_ctl_assertions (
	// Watched ports
	input wire CLK_I,
	input wire RSTN_I,
	input wire STOP_REQ_I,
	input wire CPU_ON_MAIN_I,
	input wire INT_REQ_I,
	input wire INT_MASK_I,
	input wire STOP_O,
	input wire HALT_O,
	input wire CPU_CLK_EN_O,
	input wire RESUME_O,
	input wire VECTOR_O,
	input wire RL_OSC_EN_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);
	wire run = CPU_CLK_EN_O && !STOP_O && !HALT_O;
	wire unm = INT_REQ_I && !INT_MASK_I;
	a_stop_entry: assert property (STOP_REQ_I && CPU_ON_MAIN_I && run && !unm |=> STOP_O && !CPU_CLK_EN_O)
		else $error("stop not entered");
	a_off_main: assert property (STOP_REQ_I && !CPU_ON_MAIN_I && run |=> !STOP_O && !HALT_O)
		else $error("stop taken off main clock");
	a_halt_entry: assert property (STOP_REQ_I && CPU_ON_MAIN_I && run && unm |=> HALT_O && !STOP_O)
		else $error("pending request did not give halt");
	a_masked_hold: assert property (STOP_O && !unm |=> STOP_O)
		else $error("stop left without request");
	a_wake_leave: assert property (STOP_O && unm |=> !STOP_O)
		else $error("unmasked request kept stop");
	a_no_early: assert property ($fell(STOP_O) |-> !RESUME_O [*8])
		else $error("resume too early");
	a_resume_bound: assert property ($fell(STOP_O) |-> ##[8:1000] RESUME_O)
		else $error("resume missing");
	a_vector_pair: assert property (VECTOR_O |-> RESUME_O)
		else $error("vector without resume");
	a_rl_kept: assert property ($rose(STOP_O) |-> $stable(RL_OSC_EN_O))
		else $error("low-speed osc changed at entry");
	a_reset_run: assert property ($rose(RSTN_I) |-> run)
		else $error("not running after reset");
	c_vector: cover property (RESUME_O && VECTOR_O);
	c_seq: cover property (RESUME_O && !VECTOR_O);
	c_halt: cover property ($rose(HALT_O));
endmodule

// ===== cpu_model.sv
// CPU-side model issuing the stop instruction.
// Assumes go is a one-cycle pulse from the bench.
`timescale 1ns/1ps
module cpu_model (
	// Clock and reset
	input wire clk_i,
	input wire rstn_i,
	// Bench side
	input wire go_i,
	input wire stable_i,
	// Stop request
	output reg stop_req_o
);
	reg want_q;
	// Held until the internal oscillator reads stable
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			want_q <= 1'b0;
			stop_req_o <= 1'b0;
		end else begin
			stop_req_o <= (want_q | go_i) & stable_i;
			want_q <= (want_q | go_i) & !stable_i;
		end
	end
endmodule

// ===== test_stop_mode_standby_control.sv
// Self-checking bench for stop_ctl.
// Assumes a 100 MHz clock and the cpu_model partner.
`timescale 1ns/1ps
`include "stop_ctl_defs.vh"
module test_stop_mode_standby_control;
	reg CLK_I = 0, RSTN_I = 0, WR_I = 0, RD_I = 0, go = 0, rd_d = 0;
	reg CPU_ON_MAIN_I = 1, INT_REQ_I = 0, INT_MASK_I = 1, INT_PRIO_I = 0, INT_IE_I = 0, INT_ISP_I = 0;
	reg [3:0] ADDR_I = 4'h0;
	reg [7:0] WDATA_I = 8'h00, c;
	reg v = 0, stable = 1;
	wire [7:0] RDATA_O;
	wire STOP_REQ_I, CPU_CLK_EN_O, RESUME_O, VECTOR_O, HALT_O, STOP_O, MAIN_OSC_EN_O, RL_OSC_EN_O;
	wire WDT_CLK_EN_O, UART_A_EN_O, UART_B_EN_O, CSI_EN_O, IIC_EN_O, TIMER_EN_O;
	integer failures = 0, total_checks = 0, seed = 13013, i, n;
	reg [7:0] rq[$], vq[$];
	always #5 CLK_I = ~CLK_I;
	stop_ctl u_dut (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
		.RD_I(RD_I), .RDATA_O(RDATA_O), .STOP_REQ_I(STOP_REQ_I), .CPU_ON_MAIN_I(CPU_ON_MAIN_I),
		.CPU_CLK_EN_O(CPU_CLK_EN_O), .RESUME_O(RESUME_O), .VECTOR_O(VECTOR_O), .HALT_O(HALT_O),
		.STOP_O(STOP_O), .INT_REQ_I(INT_REQ_I), .INT_MASK_I(INT_MASK_I), .INT_PRIO_I(INT_PRIO_I),
		.INT_IE_I(INT_IE_I), .INT_ISP_I(INT_ISP_I), .MAIN_OSC_EN_O(MAIN_OSC_EN_O), .RL_OSC_EN_O(RL_OSC_EN_O),
		.WDT_CLK_EN_O(WDT_CLK_EN_O), .UART_A_EN_O(UART_A_EN_O), .UART_B_EN_O(UART_B_EN_O),
		.CSI_EN_O(CSI_EN_O), .IIC_EN_O(IIC_EN_O), .TIMER_EN_O(TIMER_EN_O));
	cpu_model u_cpu (.clk_i(CLK_I), .rstn_i(RSTN_I), .go_i(go), .stable_i(stable), .stop_req_o(STOP_REQ_I));
	task check(input string nm, input [7:0] s, input [7:0] e);
		begin
			total_checks = total_checks + 1;
			if (s !== e) begin
				failures = failures + 1;
				$display("CHECK FAILED %0s exp %h seen %h", nm, e, s);
			end
		end
	endtask
	task report_and_stop;
		begin
			$display("checks %0d failures %0d", total_checks, failures);
			if (failures == 0 && total_checks > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	task wr(input [3:0] a, input [7:0] d);
		begin
			@(posedge CLK_I) {ADDR_I, WDATA_I, WR_I} <= {a, d, 1'b1};
			@(posedge CLK_I) WR_I <= 1'b0;
		end
	endtask
	task rd(input [3:0] a, input [7:0] e);
		begin
			@(posedge CLK_I) {ADDR_I, RD_I} <= {a, 1'b1};
			rq.push_back(e);
			@(posedge CLK_I) RD_I <= 1'b0;
		end
	endtask
	task stop_go;
		begin
			@(posedge CLK_I) go <= 1'b1;
			@(posedge CLK_I) go <= 1'b0;
			repeat (3) @(posedge CLK_I);
		end
	endtask
	task wait_resume;
		begin
			n = 0;
			while (RESUME_O !== 1'b1 && n < 2000) begin
				@(posedge CLK_I);
				n = n + 1;
			end
			// A release that never comes ends the run as a failure
			if (RESUME_O !== 1'b1) begin
				failures = failures + 1;
				report_and_stop;
			end
		end
	endtask
	// Oldest note is compared when a result appears
	always @(posedge CLK_I) begin
		if (rd_d) check("rdata", RDATA_O, rq.pop_front());
		if (RESUME_O === 1'b1) check("vector", 8'(VECTOR_O), vq.pop_front());
		rd_d <= RD_I;
	end
	initial begin
		#300000;
		failures = failures + 1;
		report_and_stop;
	end
	initial begin
		repeat (2) @(posedge CLK_I);
		RSTN_I <= 1'b1;
		rd(`ADDR_OSC_STAB_TIME_SELECT, 8'(`OSC_STAB_TIME_SELECT_RESET));
		rd(4'h9, 8'h00);
		rd(`ADDR_CTRL, `CTRL_RESET);
		// Short stabilisation keeps the run brief
		wr(`ADDR_OSC_STAB_TIME_SELECT, 8'h00);
		CPU_ON_MAIN_I <= 1'b0;
		stop_go;
		check("offmain", 8'(STOP_O), 8'h00);
		CPU_ON_MAIN_I <= 1'b1;
		// Request held back until the internal oscillator reads stable
		stable <= 1'b0;
		stop_go;
		check("unstable", 8'(STOP_O), 8'h00);
		stable <= 1'b1;
		repeat (3) @(posedge CLK_I);
		check("stable", 8'(STOP_O), 8'h01);
		vq.push_back(8'h00);
		{INT_REQ_I, INT_MASK_I} <= 2'b10;
		wait_resume;
		{INT_REQ_I, INT_MASK_I} <= 2'b01;
		$display("entry tests done");
		for (i = 0; i < 8; i = i + 1) begin
			c = $random(seed);
			c[7] = 1'b0;
			// First half runs on the external clock so exact waits are visible
			c[`CTRL_EXT_HS_CLK] = ~i[2];
			// Control rewritten only while running, restarting the peripherals
			wr(`ADDR_CTRL, c);
			@(posedge CLK_I) {INT_PRIO_I, INT_IE_I, INT_ISP_I, INT_REQ_I} <= {i[2:0], 1'b1};
			stop_go;
			check("wdt", 8'(WDT_CLK_EN_O), 8'(!c[`CTRL_RL_SOFT_STOP]));
			check("rl", 8'(RL_OSC_EN_O), 8'(!(c[0] & c[1])));
			check("uart", 8'({UART_A_EN_O, UART_B_EN_O}), 8'({2{c[3] & c[4]}}));
			check("csi", 8'(CSI_EN_O), 8'(c[`CTRL_CSI_EXT]));
			check("iic", 8'(IIC_EN_O), 8'(c[`CTRL_IIC_EXT]));
			check("gate", 8'({MAIN_OSC_EN_O, CPU_CLK_EN_O, TIMER_EN_O}), 8'h00);
			repeat (4) @(posedge CLK_I);
			check("hold", 8'(STOP_O), 8'h01);
			v = i[1] & (!i[2] | i[0]);
			vq.push_back(8'(v));
			INT_MASK_I <= 1'b0;
			wait_resume;
			check("fast", 8'(n < 40), 8'(c[`CTRL_EXT_HS_CLK]));
			// Request sampling, one stabilisation cycle and the output flop add three
			if (c[`CTRL_EXT_HS_CLK]) check("wait", 8'(n), (v ? `WAIT_VECTOR : `WAIT_SEQ) + 8'h03);
			check("run", 8'({MAIN_OSC_EN_O, CPU_CLK_EN_O, TIMER_EN_O, UART_A_EN_O, UART_B_EN_O, CSI_EN_O,
				IIC_EN_O}), 8'h7F);
			{INT_REQ_I, INT_MASK_I} <= 2'b01;
			rd(`ADDR_STAT, 8'h00);
			rd(`ADDR_CAUSE, {6'h00, 1'b1, v});
		end
		$display("release tests done");
		wr(`ADDR_CTRL, 8'h04);
		@(posedge CLK_I) {INT_REQ_I, INT_MASK_I, INT_PRIO_I, INT_IE_I} <= 4'b1001;
		vq.push_back(8'h01);
		stop_go;
		check("halt", 8'(HALT_O), 8'h01);
		wait_resume;
		{INT_REQ_I, INT_MASK_I} <= 2'b01;
		rd(`ADDR_STAT, 8'h04);
		stop_go;
		check("instop", 8'(STOP_O), 8'h01);
		RSTN_I <= 1'b0;
		repeat (2) @(posedge CLK_I);
		RSTN_I <= 1'b1;
		check("rst", 8'({STOP_O, CPU_CLK_EN_O}), 8'h01);
		repeat (2) @(posedge CLK_I);
		check("rstrun", 8'({STOP_O, HALT_O, CPU_CLK_EN_O, MAIN_OSC_EN_O}), 8'h03);
		rd(`ADDR_OSC_STAB_TIME_SELECT, 8'(`OSC_STAB_TIME_SELECT_RESET));
		repeat (2) @(posedge CLK_I);
		$display("halt and reset tests done");
		report_and_stop;
	end
endmodule
bind stop_ctl stop_ctl_assertions u_chk (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .STOP_REQ_I(STOP_REQ_I),
	.CPU_ON_MAIN_I(CPU_ON_MAIN_I), .INT_REQ_I(INT_REQ_I), .INT_MASK_I(INT_MASK_I), .STOP_O(STOP_O),
	.HALT_O(HALT_O), .CPU_CLK_EN_O(CPU_CLK_EN_O), .RESUME_O(RESUME_O), .VECTOR_O(VECTOR_O),
	.RL_OSC_EN_O(RL_OSC_EN_O));
